// file: hdl/watchdog_timer_halfwarn.sv
/*
 * half-warning watchdog: 16-bit up counter on a 32 kHz tick, half-way warning
 * interrupt, overflow chip reset with a flag that outlives that reset.
 * assumes a plain register port on i_clk, an oscillator tick pin from another
 * domain, and a power-on reset on i_arst_n only (chip reset is an output).
 */
`timescale 1ns/1ps
`include "wdt_halfwarn_params.svh"

module watchdog_timer_halfwarn
#(
    parameter int OSC_DIV_CYCLES = `WDT_OSC_DIV_CYCLES
)
(
    // clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_arst_n,
    // oscillator input from outside
    input  wire logic                       i_osc_32k,
    input  wire logic                       i_osc_use_pin,
    // register port
    input  wire wdt_halfwarn_pkg::addr_type i_addr,
    input  wire wdt_halfwarn_pkg::byte_type i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output      wdt_halfwarn_pkg::byte_type o_rdata,
    // global interrupt controls
    input  wire logic                       i_global_watchdog_irq_enable,
    input  wire logic                       i_irq_ack,
    // system outputs
    output      logic                       o_global_watchdog_pending,
    output      logic                       o_irq,
    output      logic                       o_wakeup,
    output      logic                       o_chip_reset
);
    import wdt_halfwarn_pkg::*;

    initial
    begin
        if (OSC_DIV_CYCLES < 1 || OSC_DIV_CYCLES > 65535)
        begin
            $error("OSC_DIV_CYCLES out of range");
        end
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [1:0]    osc_sync;
        logic          osc_last;
        logic [15:0]   div_cnt;
        logic [15:0]   count;
        logic          watchdog_enable_bit;
        logic          half_overflow_irq_enable;
        logic          half_overflow_flag;
        logic          overflow_reset_flag;
        byte_type      watchdog_compare_value;
        logic [1:0]    irq_mask;
        logic          global_watchdog_pending;
        logic          half_hit_last;
        logic          wakeup;
        logic          chip_reset;
        run_state_type run;
        byte_type      rdata;
    } state_type;

    state_type state_reg;
    state_type state_next;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input addr_type a, input addr_type off);
        hit = (a == off);
    endfunction

    logic     tick;
    logic     half_hit;
    logic     full_hit;
    logic     clear_cmd;
    logic     wr_cfg;
    logic     wr_flg;
    byte_type half_value;
    logic [1:0] flags;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;

        // oscillator tick: pin edge after two flops, or divided system clock
        state_next.osc_sync = {state_reg.osc_sync[0], i_osc_32k};
        state_next.osc_last = state_reg.osc_sync[1];
        tick = 1'b0;
        if (i_osc_use_pin)
        begin
            tick = state_reg.osc_sync[1] & ~state_reg.osc_last;
            state_next.div_cnt = 16'h0000;
        end
        else if (state_reg.div_cnt >= 16'(2 * OSC_DIV_CYCLES - 1))
        begin
            tick = 1'b1;
            state_next.div_cnt = 16'h0000;
        end
        else
        begin
            state_next.div_cnt = state_reg.div_cnt + 16'h0001;
        end

        wr_cfg    = i_wr && hit(i_addr, `WDT_CONFIG_OFFSET);
        wr_flg    = i_wr && hit(i_addr, `WDT_FLAGS_OFFSET);
        clear_cmd = wr_cfg && i_wdata[`WDT_CLEAR_BIT];
        half_value = {1'b0, state_reg.watchdog_compare_value[7:1]};
        half_hit  = state_reg.watchdog_enable_bit
                    && (state_reg.count[15:8] == half_value);
        full_hit  = state_reg.watchdog_enable_bit
                    && (state_reg.count[15:8] == state_reg.watchdog_compare_value);
        state_next.half_hit_last = half_hit;
        state_next.wakeup = 1'b0;

        // register writes
        if (wr_cfg)
        begin
            state_next.watchdog_enable_bit      = i_wdata[`WDT_ENABLE_BIT];
            state_next.half_overflow_irq_enable = i_wdata[`WDT_HALF_IRQ_EN_BIT];
        end
        if (i_wr && hit(i_addr, `WDT_COMPARE_OFFSET))
        begin
            state_next.watchdog_compare_value = i_wdata;
        end
        if (i_wr && hit(i_addr, `WDT_IRQ_MASK_OFFSET))
        begin
            state_next.irq_mask = i_wdata[1:0];
        end

        // write-one-to-clear flags, clear bit clears both
        if (wr_flg && i_wdata[`WDT_HALF_FLAG_BIT])
        begin
            state_next.half_overflow_flag = 1'b0;
        end
        if (wr_flg && i_wdata[`WDT_OVF_FLAG_BIT])
        begin
            state_next.overflow_reset_flag = 1'b0;
        end
        if (clear_cmd)
        begin
            state_next.half_overflow_flag  = 1'b0;
            state_next.overflow_reset_flag = 1'b0;
        end

        // counter
        if (clear_cmd)
        begin
            state_next.count = 16'h0000;
        end
        else if (state_reg.watchdog_enable_bit && tick)
        begin
            state_next.count = state_reg.count + 16'h0001;
        end

        // state machine: overflow drives the chip reset for one cycle
        case (state_reg.run)
            run_idle_type:
            begin
                state_next.chip_reset = 1'b0;
                if (state_reg.watchdog_enable_bit)
                begin
                    state_next.run = run_count_type;
                end
            end
            run_count_type:
            begin
                state_next.chip_reset = 1'b0;
                if (!state_reg.watchdog_enable_bit)
                begin
                    state_next.run = run_idle_type;
                end
                else if (full_hit && !clear_cmd)
                begin
                    state_next.overflow_reset_flag = 1'b1;
                    state_next.chip_reset          = 1'b1;
                    state_next.run                 = run_reset_type;
                end
            end
            run_reset_type:
            begin
                // chip reset restores control state, keeps overflow flag
                state_next.chip_reset               = 1'b0;
                state_next.count                    = 16'h0000;
                state_next.watchdog_enable_bit      = 1'b0;
                state_next.half_overflow_irq_enable = 1'b0;
                state_next.half_overflow_flag       = 1'b0;
                state_next.watchdog_compare_value   = `WDT_COMPARE_RESET;
                state_next.irq_mask                 = 2'b00;
                state_next.global_watchdog_pending  = 1'b0;
                state_next.run                      = run_idle_type;
            end
            default:
            begin
                state_next.chip_reset = 1'b0;
                state_next.run        = run_idle_type;
            end
        endcase

        // half-way event on entry to the match, set wins over ack and flag write, clear bit wins over set
        if (state_reg.run == run_count_type && half_hit && !state_reg.half_hit_last
            && !clear_cmd)
        begin
            if (state_reg.half_overflow_irq_enable)
            begin
                state_next.half_overflow_flag = 1'b1;
            end
            state_next.wakeup = 1'b1;
            if (state_reg.half_overflow_irq_enable && i_global_watchdog_irq_enable)
            begin
                state_next.global_watchdog_pending = 1'b1;
            end
        end
        else if (i_irq_ack)
        begin
            state_next.global_watchdog_pending = 1'b0;
        end

        // read data, one cycle after the strobe
        flags = {state_reg.half_overflow_flag, state_reg.overflow_reset_flag};
        state_next.rdata = 8'h00;
        if (i_rd)
        begin
            case (i_addr)
                `WDT_CONFIG_OFFSET:
                begin
                    state_next.rdata = {4'h0, state_reg.watchdog_enable_bit, 1'b0,
                                        state_reg.half_overflow_irq_enable, 1'b0};
                end
                `WDT_FLAGS_OFFSET:    state_next.rdata = {6'b00_0000, flags};
                `WDT_COMPARE_OFFSET:  state_next.rdata = state_reg.watchdog_compare_value;
                `WDT_IRQ_MASK_OFFSET: state_next.rdata = {6'b00_0000, state_reg.irq_mask};
                `WDT_COUNT_LO_OFFSET: state_next.rdata = state_reg.count[7:0];
                `WDT_COUNT_HI_OFFSET: state_next.rdata = state_reg.count[15:8];
                default:              state_next.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_rdata                   = state_reg.rdata;
    assign o_global_watchdog_pending = state_reg.global_watchdog_pending;
    assign o_irq        = |({state_reg.half_overflow_flag, state_reg.overflow_reset_flag}
                            & state_reg.irq_mask);
    assign o_wakeup     = state_reg.wakeup;
    assign o_chip_reset = state_reg.chip_reset;

endmodule

// file: hdl/wdt_halfwarn_params.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * half-warning watchdog.
 * assumes an 8-bit register port with 16-bit addresses.
 */
`ifndef WDT_HALFWARN_PARAMS_SVH
`define WDT_HALFWARN_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define WDT_CONFIG_OFFSET      16'hf100
`define WDT_FLAGS_OFFSET       16'hf101
`define WDT_COMPARE_OFFSET     16'hf102
`define WDT_IRQ_MASK_OFFSET    16'hf103
`define WDT_COUNT_LO_OFFSET    16'hf104
`define WDT_COUNT_HI_OFFSET    16'hf105

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WDT_CLEAR_BIT          0
`define WDT_HALF_IRQ_EN_BIT    1
`define WDT_ENABLE_BIT         3
`define WDT_OVF_FLAG_BIT       0
`define WDT_HALF_FLAG_BIT      1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WDT_CONFIG_RESET       8'h00
`define WDT_FLAGS_RESET        2'b00
`define WDT_COMPARE_RESET      8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WDT_SYS_CLK_HZ         40000000
`define WDT_OSC_HZ             32768
`define WDT_OSC_DIV_CYCLES     (`WDT_SYS_CLK_HZ / (2 * `WDT_OSC_HZ))
`define WDT_TICKS_PER_STEP     256

`endif

// file: hdl/wdt_halfwarn_pkg.sv
/*
 * types of the half-warning watchdog.
 * assumes the params header is included by the design file.
 */
package wdt_halfwarn_pkg;

    typedef logic [7:0]  byte_type;
    typedef logic [15:0] addr_type;

    typedef enum logic [1:0]
    {
        run_idle_type   = 2'b00,
        run_count_type  = 2'b01,
        run_reset_type  = 2'b10
    } run_state_type;

endpackage

// file: test/test_watchdog_timer_halfwarn.sv
/*
 * self-checking bench of the half-warning watchdog.
 * assumes design files and monitor compiled first; divider shortened to 1.
 */
`timescale 1ns/1ps
`include "wdt_halfwarn_params.svh"

module test_watchdog_timer_halfwarn;
    import wdt_halfwarn_pkg::*;
    logic     clk = 0, arst_n = 0, wr = 0, rd = 0, gen = 0, ack = 0;
    logic     osc = 0, pin = 0;
    logic     pend, irq, wake, rst;
    addr_type addr = '0;
    byte_type wdata = '0, rdata;
    int       n_mismatch = 0, tests_run = 0, n;

    always #12.5 clk = ~clk;
    // oscillator pin, 8 system cycles per period, edges on falling clock edges
    always #100 osc = ~osc;

    watchdog_timer_halfwarn #(.OSC_DIV_CYCLES(1)) watchdog_timer_halfwarn_i (
        .i_clk(clk), .i_arst_n(arst_n), .i_osc_32k(osc), .i_osc_use_pin(pin),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_global_watchdog_irq_enable(gen), .i_irq_ack(ack),
        .o_global_watchdog_pending(pend), .o_irq(irq), .o_wakeup(wake), .o_chip_reset(rst));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic results();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input addr_type a, input byte_type d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input addr_type a, input byte_type exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        cmp(rdata, exp);
    endtask

    // waits for wakeup (sel 0) or chip reset (sel 1), n counts cycles
    task automatic wait_sig(input int sel, input int lim);
        n = 0;
        while (((sel == 0) ? wake : rst) !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > lim)
            begin
                n_mismatch++;
                $display("ERROR t=%0t got=%h exp=%h", $time, n, lim);
                results();
            end
        end
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(`WDT_CONFIG_OFFSET, 8'h00);
        rd_chk(`WDT_FLAGS_OFFSET, 8'h00);
        rd_chk(`WDT_COMPARE_OFFSET, 8'h00);
        rd_chk(16'hf1ff, 8'h00);
        wr_reg(`WDT_COMPARE_OFFSET, 8'ha5);
        rd_chk(`WDT_COMPARE_OFFSET, 8'ha5);
        $display("test registers done");
        wr_reg(`WDT_COMPARE_OFFSET, 8'h02);
        wr_reg(`WDT_IRQ_MASK_OFFSET, 8'h02);
        rd_chk(`WDT_IRQ_MASK_OFFSET, 8'h02);
        gen <= 1'b1;
        wr_reg(`WDT_CONFIG_OFFSET, 8'h0b);
        wait_sig(0, 600);
        cmp({7'h00, n > 508 && n < 518}, 8'h01);
        rd_chk(`WDT_FLAGS_OFFSET, 8'h02);
        cmp({6'h00, pend, irq}, 8'h03);
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        @(negedge clk);
        cmp({7'h00, pend}, 8'h00);
        wr_reg(`WDT_FLAGS_OFFSET, 8'h02);
        rd_chk(`WDT_FLAGS_OFFSET, 8'h00);
        cmp({7'h00, irq}, 8'h00);
        $display("test half warning done");
        gen <= 1'b0;
        wr_reg(`WDT_CONFIG_OFFSET, 8'h0b);
        wait_sig(0, 600);
        cmp({7'h00, n > 508 && n < 518}, 8'h01);
        cmp({6'h00, pend, irq}, 8'h01);
        wr_reg(`WDT_CONFIG_OFFSET, 8'h09);
        rd_chk(`WDT_FLAGS_OFFSET, 8'h00);
        rd_chk(`WDT_CONFIG_OFFSET, 8'h08);
        $display("test clear done");
        wait_sig(1, 1100);
        cmp({7'h00, n > 1012 && n < 1022}, 8'h01);
        rd_chk(`WDT_FLAGS_OFFSET, 8'h01);
        rd_chk(`WDT_CONFIG_OFFSET, 8'h00);
        rd_chk(`WDT_COMPARE_OFFSET, 8'h00);
        wr_reg(`WDT_FLAGS_OFFSET, 8'h01);
        rd_chk(`WDT_FLAGS_OFFSET, 8'h00);
        $display("test overflow done");
        pin <= 1'b1;
        wr_reg(`WDT_COMPARE_OFFSET, 8'h10);
        wr_reg(`WDT_CONFIG_OFFSET, 8'h09);
        repeat (80) @(posedge clk);
        addr <= `WDT_COUNT_LO_OFFSET;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        cmp({7'h00, rdata > 8'h07 && rdata < 8'h0d}, 8'h01);
        $display("test oscillator pin done");
        results();
    end
endmodule

// file: test/wdt_halfwarn_monitor.sv
/*
 * checker of the half-warning watchdog, bound to its top module.
 * assumes the params header and the package are compiled first.
 */
`timescale 1ns/1ps
`include "wdt_halfwarn_params.svh"

module wdt_halfwarn_monitor
(
    // clock and reset
    input wire logic                       i_clk,
    input wire logic                       i_arst_n,
    // register port
    input wire wdt_halfwarn_pkg::addr_type i_addr,
    input wire logic                       i_rd,
    input wire wdt_halfwarn_pkg::byte_type o_rdata,
    // interrupt and system signals
    input wire logic                       i_global_watchdog_irq_enable,
    input wire logic                       i_irq_ack,
    input wire logic                       o_global_watchdog_pending,
    input wire logic                       o_wakeup,
    input wire logic                       o_chip_reset
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 8'h00;
    endproperty
    property p_unmapped;
        $past(i_rd) && $past(i_addr) > `WDT_COUNT_HI_OFFSET |-> o_rdata == 8'h00;
    endproperty
    property p_flags_bits;
        $past(i_rd) && $past(i_addr) == `WDT_FLAGS_OFFSET |-> o_rdata[7:2] == 6'h00;
    endproperty
    property p_cfg_bits;
        $past(i_rd) && $past(i_addr) == `WDT_CONFIG_OFFSET |-> o_rdata[0] == 1'b0;
    endproperty
    property p_wake_pulse;
        o_wakeup |=> !o_wakeup;
    endproperty
    property p_rst_quiet;
        o_chip_reset |=> !o_chip_reset [*8];
    endproperty
    property p_pend_global;
        $rose(o_global_watchdog_pending) |-> $past(i_global_watchdog_irq_enable);
    endproperty
    property p_pend_wake;
        $rose(o_global_watchdog_pending) |-> o_wakeup;
    endproperty
    property p_ack_clears;
        i_irq_ack |=> !o_global_watchdog_pending || o_wakeup;
    endproperty

    // ----------------------------------------------------------------
    // assertions and covers
    // ----------------------------------------------------------------
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_flags_bits: assert property (p_flags_bits) else $error("flags high bits set");
    a_cfg_bits: assert property (p_cfg_bits) else $error("clear bit reads one");
    a_wake_pulse: assert property (p_wake_pulse) else $error("wakeup too long");
    a_rst_quiet: assert property (p_rst_quiet) else $error("reset repeats");
    a_pend_global: assert property (p_pend_global) else $error("pending without enable");
    a_pend_wake: assert property (p_pend_wake) else $error("pending without event");
    a_ack_clears: assert property (p_ack_clears) else $error("ack ignored");
    c_wake: cover property (o_wakeup);
    c_rst: cover property (o_chip_reset);
    c_ack: cover property (i_irq_ack && o_global_watchdog_pending);
endmodule

bind watchdog_timer_halfwarn wdt_halfwarn_monitor wdt_halfwarn_monitor_i
(
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_global_watchdog_irq_enable(i_global_watchdog_irq_enable), .i_irq_ack(i_irq_ack),
    .o_global_watchdog_pending(o_global_watchdog_pending), .o_wakeup(o_wakeup),
    .o_chip_reset(o_chip_reset)
);
